// ### logic/fdrs_byte_queue.v
// Byte queue behind the command and data port.
// Assumes one clock and a synchronous active-high reset; push and pop
// are only asserted by the caller when not full and not empty.
`timescale 1ns/100ps
`include "fdrs_defines.vh"

module fdrs_byte_queue (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_srst,
   // Control
   input  wire       i_flush,
   input  wire       i_limit_one,
   // Fill side
   input  wire       i_push,
   input  wire [7:0] i_wdata,
   // Drain side
   input  wire       i_pop,
   output wire [7:0] o_rdata,
   // Levels
   output wire       o_full,
   output wire       o_empty
);

   reg [7:0] mem_r [0:`FDRS_Q_DEPTH-1];
   reg [3:0] wptr_r;
   reg [3:0] rptr_r;
   reg [4:0] cnt_r;

   // With the queue disabled it holds a single byte
   assign o_full  = i_limit_one ? (cnt_r >= `FDRS_Q_ONE_CNT) : (cnt_r == `FDRS_Q_FULL_CNT);
   assign o_empty = (cnt_r == 5'h00);
   assign o_rdata = mem_r[rptr_r];

   always @(posedge i_clk) begin
      if (i_push)
         mem_r[wptr_r] <= i_wdata;
   end

   always @(posedge i_clk) begin
      if (i_srst || i_flush) begin
         wptr_r <= 4'h0;
         rptr_r <= 4'h0;
         cnt_r  <= 5'h00;
      end else begin
         if (i_push)
            wptr_r <= wptr_r + 4'h1;
         if (i_pop)
            rptr_r <= rptr_r + 4'h1;
         if (i_push && !i_pop)
            cnt_r <= cnt_r + 5'h01;
         else if (i_pop && !i_push)
            cnt_r <= cnt_r - 5'h01;
      end
   end

endmodule // fdrs_byte_queue

// ### logic/fdrs_top.v
// Command and data port of the disk controller with result status bytes.
// Assumes a host on a plain strobe port and a disk engine that reports
// drive events as one-cycle pulses and levels in the controller clock.
//
// Summary of operation
// [RL1] Byte port at offset 5 holds four stacked status bytes, one shown per read.
// [RL2] Host passes command, parameter and data bytes, then reads results, through the port.
// [RL3] Byte queue disabled after reset; only the configure command enables it.
// [RL4] Status zero bits 7-6: 00 normal, 01 abnormal, 10 invalid command.
// [RL5] Termination code 11 when drive ready changes during execution.
// [RL6] Status zero bit 4 on drive fault or no track zero after 77 steps.
// [RL7] Status zero bit 3 is one when the selected drive is not ready.
// [RL8] Status zero bit 2 holds the head in use when the command ended.
// [RL9] Status zero bits 1-0 encode the selected drive A to D.
// [RL10] Status one bit 7 on access past the last sector.
// [RL11] Status one bits 6 and 3 always read zero.
// [RL12] Status one bit 5 on CRC failure in identifier or data field.
// [RL13] Status one bit 4 when the host misses a data byte during transfer.
// [RL14] Status one bit 2 when the requested sector cannot be found.
// [RL15] Status one bit 1 when write protection is seen during a write.
// [RL16] Status one bit 0 on missing or deleted data address mark.
// [RL17] Request flag high only when the port can take or give a byte.
// [RL18] Direction flag high means port to host, low means host to port.
// [RL19] Result phase gives status zero, then status one, one per host read.
// [RL20] Error bits of both status bytes clear when a new command is taken.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "fdrs_defines.vh"

module fdrs_top (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_srst,
   // Register port
   input  wire [2:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output reg  [7:0] o_rdata,
   // Command to the disk engine
   output reg        o_cmd_start,
   output reg  [4:0] o_cmd_opcode,
   output reg        o_cmd_head,
   output reg  [1:0] o_cmd_drive,
   output reg        o_exec_active,
   // Port flow flags
   output reg        o_host_transfer_request,
   output reg        o_transfer_direction,
   // Data bytes between queue and engine
   input  wire       i_disk_wreq,
   output reg  [7:0] o_disk_wbyte,
   output reg        o_disk_wvalid,
   input  wire [7:0] i_disk_rbyte,
   input  wire       i_disk_rvalid,
   // Engine and drive events
   input  wire       i_exec_done,
   input  wire       i_seek_finished,
   input  wire       i_drive_fault,
   input  wire       i_step_pulse,
   input  wire       i_track_zero,
   input  wire       i_drive_ready,
   input  wire       i_write_protect,
   input  wire       i_end_of_track,
   input  wire       i_crc_failure,
   input  wire       i_sector_missing,
   input  wire       i_address_mark_missing,
   // Later stacked status bytes
   input  wire [7:0] i_status_two,
   input  wire [7:0] i_status_three
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg  [3:0] state_r;
   reg  [3:0] state_nxt;
   reg  [4:0] opcode_r;
   reg        queue_en_r;
   reg        ready_ref_r;
   reg  [6:0] step_cnt_r;
   reg  [1:0] res_idx_r;
   reg  [1:0] res_last_r;

   // Status zero fields
   reg  [1:0] termination_code_r;
   reg        seek_finished_r;
   reg        equipment_fault_r;
   reg        drive_not_ready_r;
   reg        head_number_r;
   reg  [1:0] drive_select_code_r;

   // Status one fields
   reg        end_of_track_r;
   reg        crc_failure_r;
   reg        overrun_r;
   reg        sector_missing_r;
   reg        write_protected_hit_r;
   reg        address_mark_missing_r;

   reg  [7:0] status_two_r;
   reg  [7:0] status_three_r;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire st_idle   = state_r[0];
   wire st_param  = state_r[1];
   wire st_exec   = state_r[2];
   wire st_result = state_r[3];

   wire is_write  = (opcode_r == `FDRS_OPC_WRITE);
   wire is_read   = (opcode_r == `FDRS_OPC_READ);
   wire is_config = (opcode_r == `FDRS_OPC_CONFIG);

   wire [4:0] new_opc = i_wdata[`FDRS_OPC_MSB:0];
   wire new_valid = (new_opc == `FDRS_OPC_WRITE) || (new_opc == `FDRS_OPC_READ) ||
                    (new_opc == `FDRS_OPC_SEEK) || (new_opc == `FDRS_OPC_CONFIG) ||
                    (new_opc == `FDRS_OPC_VERIFY);

   wire q_full;
   wire q_empty;
   wire [7:0] q_head;

   // Port can move a byte, and which way
   wire rqm_c = st_idle || st_param || st_result ||
                (st_exec && (is_write ? !q_full : (is_read && !q_empty))); // see [RL17]
   wire dio_c = st_result || (st_exec && is_read);                      // see [RL18]

   wire port_wr = i_wr && (i_addr == `FDRS_OFS_DATA) && rqm_c && !dio_c; // see [RL2]
   wire port_rd = i_rd && (i_addr == `FDRS_OFS_DATA) && rqm_c && dio_c;

   // ----------------------------------------------------------------------
   // Queue traffic during execution
   // ----------------------------------------------------------------------
   wire host_push = st_exec && is_write && port_wr;
   wire host_pop  = st_exec && is_read && port_rd;
   wire disk_push = st_exec && is_read && i_disk_rvalid && !q_full;
   wire disk_pop  = st_exec && is_write && i_disk_wreq && !q_empty;

   wire q_push = host_push || disk_push;
   wire q_pop  = host_pop || disk_pop;
   wire q_flush = st_idle && port_wr;

   // Host missed a byte: engine found the queue full or empty
   wire miss_c = st_exec && ((is_read && i_disk_rvalid && q_full) ||
                             (is_write && i_disk_wreq && q_empty)); // see [RL13]

   // ----------------------------------------------------------------------
   // Execution events
   // ----------------------------------------------------------------------
   wire ready_chg = st_exec && (i_drive_ready != ready_ref_r);                     // see [RL5]
   wire step_out  = i_step_pulse && !i_track_zero && (step_cnt_r == `FDRS_STEP_LIMIT - 7'h01);
   wire fault_c   = st_exec && (i_drive_fault || step_out);                        // see [RL6]
   wire wp_c      = st_exec && is_write && i_write_protect;                        // see [RL15]
   wire abort_c   = ready_chg || fault_c || wp_c || miss_c;
   wire end_c     = st_exec && (i_exec_done || abort_c);

   wire err_any = fault_c || wp_c || miss_c || equipment_fault_r || overrun_r ||
                  write_protected_hit_r || end_of_track_r || crc_failure_r ||
                  sector_missing_r || address_mark_missing_r ||
                  (i_exec_done && (i_end_of_track || i_crc_failure ||
                                   i_sector_missing || i_address_mark_missing));

   // ----------------------------------------------------------------------
   // Stacked status bytes
   // ----------------------------------------------------------------------
   wire [7:0] status_zero = {termination_code_r, seek_finished_r, equipment_fault_r,
                             drive_not_ready_r, head_number_r, drive_select_code_r};
   wire [7:0] status_one  = {end_of_track_r, 1'b0, crc_failure_r, overrun_r,
                             1'b0, sector_missing_r, write_protected_hit_r,
                             address_mark_missing_r}; // see [RL11]

   reg [7:0] stack_byte;
   always @* begin
      case (res_idx_r)
         2'h0:    stack_byte = status_zero;  // see [RL19]
         2'h1:    stack_byte = status_one;
         2'h2:    stack_byte = status_two_r;
         default: stack_byte = status_three_r;
      endcase
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `FDRS_ST_IDLE: begin
            if (port_wr)
               state_nxt = new_valid ? `FDRS_ST_PARAM : `FDRS_ST_RESULT;
         end
         `FDRS_ST_PARAM: begin
            if (port_wr)
               state_nxt = is_config ? `FDRS_ST_IDLE : `FDRS_ST_EXEC;
         end
         `FDRS_ST_EXEC: begin
            if (end_c)
               state_nxt = `FDRS_ST_RESULT;
         end
         `FDRS_ST_RESULT: begin
            if (port_rd && (res_idx_r == res_last_r))
               state_nxt = `FDRS_ST_IDLE;
         end
         default: state_nxt = `FDRS_ST_IDLE;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         state_r     <= `FDRS_ST_IDLE;
         opcode_r    <= 5'h00;
         queue_en_r  <= 1'b0; // see [RL3]
         ready_ref_r <= 1'b0;
         step_cnt_r  <= 7'h00;
         res_idx_r   <= 2'h0;
         res_last_r  <= `FDRS_RES_LAST_FULL;
      end else begin
         state_r <= state_nxt;
         if (st_idle && port_wr) begin
            opcode_r   <= new_opc;
            res_idx_r  <= 2'h0;
            res_last_r <= new_valid ? `FDRS_RES_LAST_FULL : `FDRS_RES_LAST_ONE;
         end
         if (st_param && port_wr) begin
            if (is_config)
               queue_en_r <= !i_wdata[`FDRS_PAR_QDIS]; // see [RL3]
            ready_ref_r <= i_drive_ready;
            step_cnt_r  <= 7'h00;
         end
         if (st_exec) begin
            if (i_track_zero)
               step_cnt_r <= 7'h00;
            else if (i_step_pulse)
               step_cnt_r <= step_cnt_r + 7'h01;
         end
         if (st_result && port_rd)
            res_idx_r <= res_idx_r + 2'h1; // see [RL19]
      end
   end

   // ----------------------------------------------------------------------
   // Status fields
   // ----------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         termination_code_r     <= `FDRS_TERM_NORMAL;
         seek_finished_r        <= 1'b0;
         equipment_fault_r      <= 1'b0;
         drive_not_ready_r      <= 1'b0;
         head_number_r          <= 1'b0;
         drive_select_code_r    <= 2'h0;
         end_of_track_r         <= 1'b0;
         crc_failure_r          <= 1'b0;
         overrun_r              <= 1'b0;
         sector_missing_r       <= 1'b0;
         write_protected_hit_r  <= 1'b0;
         address_mark_missing_r <= 1'b0;
         status_two_r           <= `FDRS_BYTE_ZERO;
         status_three_r         <= `FDRS_BYTE_ZERO;
      end else if (st_idle && port_wr) begin
         // New command starts with a clean result
         termination_code_r     <= new_valid ? `FDRS_TERM_NORMAL
                                             : `FDRS_TERM_INVALID;          // see [RL4]
         seek_finished_r        <= 1'b0;                                     // see [RL20]
         equipment_fault_r      <= 1'b0;
         drive_not_ready_r      <= 1'b0;
         end_of_track_r         <= 1'b0;
         crc_failure_r          <= 1'b0;
         overrun_r              <= 1'b0;
         sector_missing_r       <= 1'b0;
         write_protected_hit_r  <= 1'b0;
         address_mark_missing_r <= 1'b0;
         status_two_r           <= `FDRS_BYTE_ZERO;
         status_three_r         <= `FDRS_BYTE_ZERO;
      end else if (st_param && port_wr && !is_config) begin
         head_number_r       <= i_wdata[`FDRS_PAR_HEAD];                     // see [RL8]
         drive_select_code_r <= i_wdata[`FDRS_PAR_DRV_HI:0];                 // see [RL9]
      end else if (st_exec) begin
         if (i_seek_finished)
            seek_finished_r <= 1'b1;
         if (fault_c)
            equipment_fault_r <= 1'b1;                                       // see [RL6]
         if (miss_c)
            overrun_r <= 1'b1;                                               // see [RL13]
         if (wp_c)
            write_protected_hit_r <= 1'b1;                                   // see [RL15]
         if (i_exec_done && i_end_of_track)
            end_of_track_r <= 1'b1;                                          // see [RL10]
         if (i_exec_done && i_crc_failure)
            crc_failure_r <= 1'b1;                                           // see [RL12]
         if (i_exec_done && i_sector_missing)
            sector_missing_r <= 1'b1;                                        // see [RL14]
         if (i_exec_done && i_address_mark_missing)
            address_mark_missing_r <= 1'b1;                                  // see [RL16]
         if (end_c) begin
            drive_not_ready_r <= !i_drive_ready;                             // see [RL7]
            status_two_r      <= i_status_two;
            status_three_r    <= i_status_three;
            if (ready_chg)
               termination_code_r <= `FDRS_TERM_READY;                      // see [RL5]
            else if (err_any)
               termination_code_r <= `FDRS_TERM_ABNORMAL;                   // see [RL4]
            else
               termination_code_r <= `FDRS_TERM_NORMAL;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Byte queue
   // ----------------------------------------------------------------------
   fdrs_byte_queue u_queue (
      .i_clk       (i_clk),
      .i_srst      (i_srst),
      .i_flush     (q_flush),
      .i_limit_one (!queue_en_r),
      .i_push      (q_push),
      .i_wdata     (host_push ? i_wdata : i_disk_rbyte),
      .i_pop       (q_pop),
      .o_rdata     (q_head),
      .o_full      (q_full),
      .o_empty     (q_empty)
   );

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= `FDRS_BYTE_ZERO;
      end else if (i_rd) begin
         if (i_addr == `FDRS_OFS_DATA) begin
            if (!port_rd)
               o_rdata <= `FDRS_BYTE_ZERO;
            else if (st_result)
               o_rdata <= stack_byte;                                        // see [RL1]
            else
               o_rdata <= q_head;
         end else if (i_addr == `FDRS_OFS_MSR) begin
            o_rdata <= `FDRS_BYTE_ZERO;
            o_rdata[`FDRS_MSR_RQM]  <= rqm_c;                                // see [RL17]
            o_rdata[`FDRS_MSR_DIO]  <= dio_c;                                // see [RL18]
            o_rdata[`FDRS_MSR_EXEC] <= st_exec;
            o_rdata[`FDRS_MSR_BUSY] <= !st_idle;
            o_rdata[`FDRS_MSR_QEN]  <= queue_en_r;
         end else begin
            o_rdata <= `FDRS_BYTE_ZERO;
         end
      end else begin
         o_rdata <= `FDRS_BYTE_ZERO;
      end
   end

   // ----------------------------------------------------------------------
   // Engine side outputs and flags
   // ----------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_cmd_start             <= 1'b0;
         o_cmd_opcode            <= 5'h00;
         o_cmd_head              <= 1'b0;
         o_cmd_drive             <= 2'h0;
         o_exec_active           <= 1'b0;
         o_host_transfer_request <= 1'b0;
         o_transfer_direction    <= 1'b0;
         o_disk_wbyte            <= `FDRS_BYTE_ZERO;
         o_disk_wvalid           <= 1'b0;
      end else begin
         o_cmd_start <= st_param && port_wr && !is_config;
         if (st_param && port_wr && !is_config) begin
            o_cmd_opcode <= opcode_r;
            o_cmd_head   <= i_wdata[`FDRS_PAR_HEAD];
            o_cmd_drive  <= i_wdata[`FDRS_PAR_DRV_HI:0];
         end
         o_exec_active           <= state_nxt[2];
         o_host_transfer_request <= rqm_c;                                   // see [RL17]
         o_transfer_direction    <= dio_c;                                   // see [RL18]
         o_disk_wvalid           <= disk_pop;
         if (disk_pop)
            o_disk_wbyte <= q_head;
      end
   end

endmodule // fdrs_top

// ### shared/fdrs_defines.vh
// Constants for the floppy result status block: port offsets, status
// byte fields, command codes, sequencer states and queue geometry.
// Assumes inclusion by every design file of the block, by bare name.
`ifndef FDRS_DEFINES_VH
`define FDRS_DEFINES_VH

// ----------------------------------------------------------------------
// Register port offsets
// ----------------------------------------------------------------------
`define FDRS_OFS_MSR        3'h4
`define FDRS_OFS_DATA       3'h5

// ----------------------------------------------------------------------
// Port status byte fields
// ----------------------------------------------------------------------
`define FDRS_MSR_RQM        7
`define FDRS_MSR_DIO        6
`define FDRS_MSR_EXEC       5
`define FDRS_MSR_BUSY       4
`define FDRS_MSR_QEN        3

// ----------------------------------------------------------------------
// Termination codes of status byte zero
// ----------------------------------------------------------------------
`define FDRS_TERM_NORMAL    2'h0
`define FDRS_TERM_ABNORMAL  2'h1
`define FDRS_TERM_INVALID   2'h2
`define FDRS_TERM_READY     2'h3

// ----------------------------------------------------------------------
// Command opcodes (low five bits of the command byte)
// ----------------------------------------------------------------------
`define FDRS_OPC_MSB        4
`define FDRS_OPC_WRITE      5'h05
`define FDRS_OPC_READ       5'h06
`define FDRS_OPC_SEEK       5'h0F
`define FDRS_OPC_CONFIG     5'h13
`define FDRS_OPC_VERIFY     5'h16

// ----------------------------------------------------------------------
// Parameter byte fields
// ----------------------------------------------------------------------
`define FDRS_PAR_QDIS       6
`define FDRS_PAR_HEAD       2
`define FDRS_PAR_DRV_HI     1

// ----------------------------------------------------------------------
// Sequencer states, one-hot
// ----------------------------------------------------------------------
`define FDRS_ST_IDLE        4'h1
`define FDRS_ST_PARAM       4'h2
`define FDRS_ST_EXEC        4'h4
`define FDRS_ST_RESULT      4'h8

// ----------------------------------------------------------------------
// Result stack and counts
// ----------------------------------------------------------------------
`define FDRS_RES_LAST_FULL  2'h3
`define FDRS_RES_LAST_ONE   2'h0
`define FDRS_STEP_LIMIT     7'h4D
`define FDRS_Q_DEPTH        16
`define FDRS_Q_FULL_CNT     5'h10
`define FDRS_Q_ONE_CNT      5'h01
`define FDRS_BYTE_ZERO      8'h00

`endif

// ### verification/fdrs_engine_model.sv
// Disk engine model: answers each start with steps for a seek, then done and errors unless aborted.
// Assumes the bench sets latency, steps and errors before the start.
`timescale 1ns/100ps
`include "fdrs_defines.vh"
module fdrs_engine_model (
   input  wire       i_clk,
   input  wire       i_start,
   input  wire [4:0] i_opcode,
   input  wire       i_active,
   input  wire [7:0] i_lat,
   input  wire [7:0] i_steps,
   input  wire [3:0] i_errs,
   output reg        o_done = 1'b0,
   output reg        o_seek_end = 1'b0,
   output reg        o_step = 1'b0,
   output reg  [3:0] o_err = 4'hF
);
integer k;
always begin
   @(posedge i_clk);
   if (i_start) begin
      repeat (i_lat) @(posedge i_clk);
      for (k = 0; k < i_steps && i_opcode == `FDRS_OPC_SEEK && i_active; k = k + 1) begin
         o_step <= 1'b1;
         @(posedge i_clk);
         o_step <= 1'b0;
         @(posedge i_clk);
      end
      @(posedge i_clk);
      // Aborted commands get no done; error lines are garbage outside it
      if (i_active) begin
         o_done <= 1'b1;
         o_seek_end <= (i_opcode == `FDRS_OPC_SEEK);
         o_err <= i_errs;
         @(posedge i_clk);
      end
      o_done <= 1'b0;
      o_seek_end <= 1'b0;
      o_err <= ~i_errs;
   end
end
endmodule // fdrs_engine_model

// ### verification/fdrs_top_properties.sv
// Checker on the port pins of the result status block.
// Assumes it is bound onto fdrs_top with one clock and sync reset.
`timescale 1ns/100ps
`include "fdrs_defines.vh"
module fdrs_chk (
   input wire       i_clk,
   input wire       i_srst,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire       i_wr,
   input wire       i_rd,
   input wire [7:0] o_rdata,
   input wire       o_cmd_start,
   input wire       o_cmd_head,
   input wire [1:0] o_cmd_drive,
   input wire       o_exec_active,
   input wire       o_host_transfer_request,
   input wire       o_transfer_direction
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_srst);
AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
   else $error("read data outside answer cycle");
AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) != `FDRS_OFS_DATA
   && $past(i_addr) != `FDRS_OFS_MSR |-> o_rdata == 8'h00)
   else $error("unmapped read not zero");
AST_START_CAUSE: assert property (o_cmd_start |->
   $past(i_wr) && $past(i_addr) == `FDRS_OFS_DATA)
   else $error("start without port write");
AST_START_PULSE: assert property (o_cmd_start |=> !o_cmd_start)
   else $error("start longer than one cycle");
AST_SELECT_ECHO: assert property (o_cmd_start |->
   ($past(i_wdata) & 8'h07) == {5'h00, o_cmd_head, o_cmd_drive})
   else $error("head or drive differs from parameter");
AST_EXEC_FOLLOWS: assert property (o_cmd_start |-> ##[0:1] o_exec_active)
   else $error("no execution after start");
AST_RESULT_FLAGS: assert property ($fell(o_exec_active) |->
   ##[0:2] (o_host_transfer_request && o_transfer_direction))
   else $error("result flags missing");
AST_RESET_FLAGS: assert property ($fell(i_srst) |->
   ##[0:2] (o_host_transfer_request && !o_transfer_direction))
   else $error("idle flags missing");
endmodule // fdrs_chk

bind fdrs_top fdrs_chk u_chk (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .o_cmd_start, .o_cmd_head, .o_cmd_drive, .o_exec_active,
   .o_host_transfer_request, .o_transfer_direction);

// ### verification/tb_top.sv
// Bench: host bus cycles on the port, result bytes checked from a queue.
// Assumes fdrs_top, the engine model and the bound checker.
`timescale 1ns/100ps
module tb_top;
reg i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
reg rdy = 1'b1, fault = 1'b0, wp = 1'b0, dreq = 1'b0;
reg [2:0] i_addr = 3'h0;
reg [7:0] i_wdata = 8'h00, st2 = 8'h00, st3 = 8'h00, lat = 8'h04, steps = 8'h00, par;
reg [3:0] errs = 4'h0;
reg [15:0] expq[$];
wire [7:0] rdata;
wire start, act, req, dir, done, seek, step;
wire [4:0] opc;
wire [3:0] err;
integer failures = 0, n_compared = 0, cyc = 0, seed = 32'h887662c7, i, w;
always #5 i_clk = ~i_clk;
fdrs_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_cmd_start(start), .o_cmd_opcode(opc),
   .o_cmd_head(), .o_cmd_drive(), .o_exec_active(act), .o_host_transfer_request(req),
   .o_transfer_direction(dir), .i_disk_wreq(dreq), .o_disk_wbyte(), .o_disk_wvalid(),
   .i_disk_rbyte(8'h00), .i_disk_rvalid(1'b0), .i_exec_done(done),
   .i_seek_finished(seek), .i_drive_fault(fault), .i_step_pulse(step),
   .i_track_zero(1'b0), .i_drive_ready(rdy), .i_write_protect(wp),
   .i_end_of_track(err[3]), .i_crc_failure(err[2]), .i_sector_missing(err[1]),
   .i_address_mark_missing(err[0]), .i_status_two(st2), .i_status_three(st3));
fdrs_engine_model eng (.i_clk(i_clk), .i_start(start), .i_opcode(opc), .i_active(act),
   .i_lat(lat), .i_steps(steps), .i_errs(errs), .o_done(done), .o_seek_end(seek),
   .o_step(step), .o_err(err));
task end_sim;
   begin
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
endtask
task wr(input [2:0] a, input [7:0] d);
   begin
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   end
endtask
task rd(input [2:0] a, input [7:0] e, input [7:0] m);
   begin
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      expq.push_back({e, m});
      @(posedge i_clk);
      i_rd <= 1'b0;
   end
endtask
task wres;
   begin
      w = 0;
      while (!(req === 1'b1 && dir === 1'b1) && w < 300) begin
         @(posedge i_clk);
         w = w + 1;
      end
      if (w == 300) begin
         failures = failures + 1;
         $display("BAD result_flags exp 1 got 0");
      end
   end
endtask
task res(input [7:0] e0, input [7:0] e1);
   begin
      wres;
      rd(3'h5, e0, 8'hFF);
      rd(3'h5, e1, 8'hFF);
      rd(3'h5, st2, 8'hFF);
      rd(3'h5, st3, 8'hFF);
      rd(3'h5, 8'h00, 8'hFF);
   end
endtask
always @(posedge i_clk) begin
   if (rd_seen) begin
      n_compared = n_compared + 1;
      if ((rdata & expq[0][7:0]) !== expq[0][15:8]) begin
         failures = failures + 1;
         $display("BAD o_rdata exp %h got %h", expq[0][15:8], rdata);
      end
      expq.pop_front();
   end
   rd_seen <= i_rd;
   cyc = cyc + 1;
   if (cyc == 20000) begin
      failures = failures + 1;
      end_sim;
   end
end
initial begin
   repeat (10) @(posedge i_clk);
   i_srst <= 1'b0;
   rd(3'h4, 8'h80, 8'hC8);
   wr(3'h5, 8'h13);
   wr(3'h5, 8'h00);
   rd(3'h4, 8'h88, 8'hC8);
   rd(3'h7, 8'h00, 8'hFF);
   wr(3'h5, 8'h01);
   wres;
   rd(3'h5, 8'h80, 8'hFF);
   rd(3'h5, 8'h00, 8'hFF);
   for (i = 0; i < 40; i = i + 1) begin
      par = $random(seed);
      errs <= $random(seed);
      lat <= 8'h02 + ($random(seed) & 8'h0F);
      st2 <= $random(seed);
      st3 <= $random(seed);
      wr(3'h5, i[0] ? 8'h06 : 8'h16);
      wr(3'h5, par);
      res({(|errs) ? 2'h1 : 2'h0, 3'h0, par[2:0]}, {errs[3], 1'b0, errs[2], 2'h0,
         errs[1], 1'b0, errs[0]});
   end
   errs <= 4'h0;
   for (i = 76; i < 78; i = i + 1) begin
      steps <= i;
      par = i;
      wr(3'h5, 8'h0F);
      wr(3'h5, par);
      res((i == 77) ? {2'h1, 3'h2, par[2:0]} : {2'h0, 3'h4, par[2:0]}, 8'h00);
   end
   lat <= 8'h28;
   for (i = 0; i < 2; i = i + 1) begin
      par = $random(seed);
      wr(3'h5, 8'h16);
      wr(3'h5, par);
      repeat (5) @(posedge i_clk);
      rdy <= (i != 0);
      fault <= (i != 0);
      @(posedge i_clk);
      fault <= 1'b0;
      res(i ? {2'h1, 3'h2, par[2:0]} : {2'h3, 3'h1, par[2:0]}, 8'h00);
      rdy <= 1'b1;
   end
   for (i = 0; i < 2; i = i + 1) begin
      wp <= (i == 0);
      dreq <= (i != 0);
      wr(3'h5, 8'h05);
      wr(3'h5, 8'h03);
      res({2'h1, 3'h0, 3'h3}, i ? 8'h10 : 8'h02);
   end
   end_sim;
end
endmodule // tb_top
